// ### rtl/rtc_device.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module rtc_device #(
   parameter int REC_CYCLES = rtc_pkg::REC_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic osc_tick,
   input wire logic backup,
   input wire logic [7:0] cur_sec,
   input wire logic [7:0] cur_min,
   input wire logic [7:0] cur_hour,
   input wire logic [7:0] cur_date,
   input wire logic [7:0] cur_month,
   rtc_link_if.device lnk
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] wd;
      logic [7:0] almon;
      logic [7:0] aldate;
      logic [7:0] alhour;
      logic [7:0] almin;
      logic [7:0] alsec;
      logic [7:0] sqr;
      logic af;
      logic wd_flag;
      logic alm_irq;
      logic wd_irq;
      logic [4:0] ptr;
      logic [15:0] osc_cnt;
      logic [17:0] wd_ticks;
      logic [4:0] wd_units;
      logic kick_prev;
      logic [20:0] rec_cnt;
      logic ack;
      logic [7:0] rdata;
      logic int_oe;
      logic rst_oe;
      logic sqw;
   } dev_state_t;

   dev_state_t st_ff;
   dev_state_t nxt_st;

   function automatic logic [17:0] res_ticks(input logic [1:0] rb);
      case (rb)
         2'b00: res_ticks = rtc_pkg::RES_16TH;
         2'b01: res_ticks = rtc_pkg::RES_QTR;
         2'b10: res_ticks = rtc_pkg::RES_1S;
         default: res_ticks = rtc_pkg::RES_4S;
      endcase
   endfunction : res_ticks

   function automatic logic alarm_hit(input dev_state_t s, input logic [7:0] sec,
                                      input logic [7:0] mn, input logic [7:0] hr,
                                      input logic [7:0] dt, input logic [7:0] mo);
      logic [4:0] rpt;
      logic m_s;
      logic m_m;
      logic m_h;
      logic m_d;
      logic m_mo;
      rpt = {s.aldate[rtc_pkg::B_RPT5], s.aldate[rtc_pkg::B_RPT_HI],
             s.alhour[rtc_pkg::B_RPT_HI], s.almin[rtc_pkg::B_RPT_HI],
             s.alsec[rtc_pkg::B_RPT_HI]};
      m_s = s.alsec[6:0] == sec[6:0];
      m_m = s.almin[6:0] == mn[6:0];
      m_h = s.alhour[5:0] == hr[5:0];
      m_d = s.aldate[5:0] == dt[5:0];
      m_mo = s.almon[4:0] == mo[4:0];
      case (rpt)
         5'b11110: alarm_hit = m_s;
         5'b11100: alarm_hit = m_s & m_m;
         5'b11000: alarm_hit = m_s & m_m & m_h;
         5'b10000: alarm_hit = m_s & m_m & m_h & m_d;
         5'b00000: alarm_hit = m_s & m_m & m_h & m_d & m_mo;
         default: alarm_hit = 1'b1;
      endcase
   endfunction : alarm_hit

   always_comb begin
      logic sec_tick;
      logic kick_edge;
      logic wd_wr;
      logic expire;
      logic [3:0] rate;
      logic ft_ok;
      sec_tick = 1'b0;
      kick_edge = 1'b0;
      wd_wr = 1'b0;
      expire = 1'b0;
      rate = 4'h0;
      ft_ok = 1'b0;
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.kick_prev = lnk.kick;
      kick_edge = lnk.kick != st_ff.kick_prev;
      if (osc_tick) begin
         nxt_st.osc_cnt = st_ff.osc_cnt + 16'h0001;
         sec_tick = st_ff.osc_cnt == 16'hFFFF;
      end
      if (st_ff.rec_cnt != 21'h000000) begin
         nxt_st.rec_cnt = st_ff.rec_cnt - 21'h000001;
      end
      // register access; clears come first so a same-cycle event wins
      if (lnk.req) begin
         nxt_st.ack = 1'b1;
         nxt_st.ptr = lnk.addr + 5'h01;
         if (lnk.wr) begin
            case (lnk.addr)
               rtc_pkg::A_CTRL: nxt_st.ctrl = lnk.wdata;
               rtc_pkg::A_WD: begin
                  nxt_st.wd = lnk.wdata;
                  wd_wr = 1'b1;
                  if (lnk.wdata == rtc_pkg::ZERO8) begin
                     nxt_st.wd_irq = 1'b0;
                  end
               end
               rtc_pkg::A_ALMON: nxt_st.almon = lnk.wdata;
               rtc_pkg::A_ALDATE: nxt_st.aldate = lnk.wdata;
               rtc_pkg::A_ALHOUR: nxt_st.alhour = lnk.wdata;
               rtc_pkg::A_ALMIN: nxt_st.almin = lnk.wdata;
               rtc_pkg::A_ALSEC: nxt_st.alsec = lnk.wdata;
               rtc_pkg::A_SQR: nxt_st.sqr = {lnk.wdata[7:4], 4'h0};
               default: nxt_st.rdata = st_ff.rdata;
            endcase
         end else begin
            case (lnk.addr)
               rtc_pkg::A_CTRL: nxt_st.rdata = st_ff.ctrl;
               rtc_pkg::A_WD: nxt_st.rdata = st_ff.wd;
               rtc_pkg::A_ALMON: nxt_st.rdata = st_ff.almon;
               rtc_pkg::A_ALDATE: nxt_st.rdata = st_ff.aldate;
               rtc_pkg::A_ALHOUR: nxt_st.rdata = st_ff.alhour;
               rtc_pkg::A_ALMIN: nxt_st.rdata = st_ff.almin;
               rtc_pkg::A_ALSEC: nxt_st.rdata = st_ff.alsec;
               rtc_pkg::A_FLAGS: begin
                  // old value returned, flags then drop
                  nxt_st.rdata = {st_ff.wd_flag, st_ff.af, 6'h00};
                  nxt_st.af = 1'b0;
                  nxt_st.alm_irq = 1'b0;
                  nxt_st.wd_flag = 1'b0;
               end
               rtc_pkg::A_SQR: nxt_st.rdata = st_ff.sqr;
               default: nxt_st.rdata = rtc_pkg::ZERO8;
            endcase
         end
      end
      // watchdog countdown; counting starts at restart, so error stays under one unit
      if (osc_tick && st_ff.wd[6:2] != 5'h00) begin
         if (st_ff.wd_ticks == 18'h00000) begin
            nxt_st.wd_ticks = res_ticks(st_ff.wd[1:0]) - 18'h00001;
            if (st_ff.wd_units <= 5'h01) begin
               expire = 1'b1;
               nxt_st.wd_units = st_ff.wd[6:2];
            end else begin
               nxt_st.wd_units = st_ff.wd_units - 5'h01;
            end
         end else begin
            nxt_st.wd_ticks = st_ff.wd_ticks - 18'h00001;
         end
      end
      if (expire) begin
         nxt_st.wd_flag = 1'b1;
         if (st_ff.wd[rtc_pkg::B_WDS]) begin
            nxt_st.rec_cnt = 21'(REC_CYCLES);
            nxt_st.wd = rtc_pkg::ZERO8;
            nxt_st.almon[rtc_pkg::B_AFE] = 1'b0;
            nxt_st.almon[rtc_pkg::B_ABE] = 1'b0;
            nxt_st.almon[rtc_pkg::B_SQUARE_OUTPUT_ENABLE] = 1'b0;
            nxt_st.ctrl[rtc_pkg::B_FT] = 1'b0;
         end else begin
            nxt_st.wd_irq = 1'b1;
         end
      end
      if (kick_edge || wd_wr) begin
         nxt_st.wd_ticks = res_ticks(nxt_st.wd[1:0]) - 18'h00001;
         nxt_st.wd_units = nxt_st.wd[6:2];
      end
      // alarm: once per second, blocked while the pointer sits on flags
      if (sec_tick && st_ff.ptr != rtc_pkg::A_FLAGS &&
          alarm_hit(st_ff, cur_sec, cur_min, cur_hour, cur_date, cur_month)) begin
         nxt_st.af = 1'b1;
         if (st_ff.almon[rtc_pkg::B_AFE] &&
             (!backup || st_ff.almon[rtc_pkg::B_ABE])) begin
            nxt_st.alm_irq = 1'b1;
         end
      end
      // shared pin priority: watchdog, alarm, test, level
      ft_ok = nxt_st.ctrl[rtc_pkg::B_FT] && !nxt_st.almon[rtc_pkg::B_AFE] &&
              (nxt_st.wd[rtc_pkg::B_WDS] || nxt_st.wd == rtc_pkg::ZERO8);
      if (nxt_st.wd_irq && !nxt_st.wd[rtc_pkg::B_WDS]) begin
         nxt_st.int_oe = 1'b1;
      end else if (nxt_st.alm_irq) begin
         nxt_st.int_oe = 1'b1;
      end else if (ft_ok) begin
         nxt_st.int_oe = !nxt_st.osc_cnt[rtc_pkg::FT_BIT];
      end else if (!nxt_st.ctrl[rtc_pkg::B_FT] && !nxt_st.almon[rtc_pkg::B_AFE] &&
                   nxt_st.wd == rtc_pkg::ZERO8) begin
         nxt_st.int_oe = !nxt_st.ctrl[rtc_pkg::B_OUT];
      end else begin
         nxt_st.int_oe = 1'b0;
      end
      nxt_st.rst_oe = nxt_st.rec_cnt != 21'h000000;
      rate = nxt_st.sqr[7:4];
      if (!nxt_st.almon[rtc_pkg::B_SQUARE_OUTPUT_ENABLE] || rate == 4'h0) begin
         nxt_st.sqw = 1'b0;
      end else if (rate == 4'h1) begin
         nxt_st.sqw = nxt_st.osc_cnt[0];
      end else begin
         nxt_st.sqw = nxt_st.osc_cnt[rate];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.ctrl <= rtc_pkg::CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lnk.ack = st_ff.ack;
   assign lnk.rdata = st_ff.rdata;
   assign lnk.int_o = 1'b0;
   assign lnk.int_oe = st_ff.int_oe;
   assign lnk.rst_o = 1'b0;
   assign lnk.rst_oe = st_ff.rst_oe;
   assign lnk.sqw = st_ff.sqw;
endmodule : rtc_device

// ### rtl/rtc_pkg.sv
package rtc_pkg;
   // device register map (byte addresses on the link)
   localparam logic [4:0] A_CTRL = 5'h08;
   localparam logic [4:0] A_WD = 5'h09;
   localparam logic [4:0] A_ALMON = 5'h0A;
   localparam logic [4:0] A_ALDATE = 5'h0B;
   localparam logic [4:0] A_ALHOUR = 5'h0C;
   localparam logic [4:0] A_ALMIN = 5'h0D;
   localparam logic [4:0] A_ALSEC = 5'h0E;
   localparam logic [4:0] A_FLAGS = 5'h0F;
   localparam logic [4:0] A_SQR = 5'h13;
   // field positions
   localparam int B_OUT = 7;
   localparam int B_FT = 6;
   localparam int B_WDS = 7;
   localparam int B_AFE = 7;
   localparam int B_SQUARE_OUTPUT_ENABLE = 6;
   localparam int B_ABE = 5;
   localparam int B_WDF = 7;
   localparam int B_AF = 6;
   localparam int B_RPT_HI = 7;
   localparam int B_RPT5 = 6;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h80;
   localparam logic [7:0] ZERO8 = 8'h00;
   // oscillator tick is 65.536 kHz; watchdog resolutions in ticks
   localparam logic [17:0] RES_16TH = 18'h01000;
   localparam logic [17:0] RES_QTR = 18'h04000;
   localparam logic [17:0] RES_1S = 18'h10000;
   localparam logic [17:0] RES_4S = 18'h40000;
   localparam int FT_BIT = 6;
   // reset pulse length
   localparam int CLK_NS = 50;
   localparam int REC_MS = 96;
   localparam int REC_CYC = REC_MS * 1000000 / CLK_NS;
   // host-side registers on AXI4-Lite
   localparam logic [7:0] H_ADDR = 8'h00;
   localparam logic [7:0] H_WDATA = 8'h04;
   localparam logic [7:0] H_READ = 8'h08;
   localparam logic [7:0] H_STAT = 8'h0C;
   localparam logic [7:0] H_KICK = 8'h10;
   localparam int H_BUSY = 8;
   localparam logic [1:0] OKAY = 2'h0;
   localparam logic [1:0] SLVERR = 2'h2;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_REQ = 2'b01,
      H_WAIT = 2'b10
   } hstate_t;
endpackage : rtc_pkg

// ### rtl/rtc_link_if.sv
`timescale 1ns/1ps
interface rtc_link_if;
   logic req;
   logic wr;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic kick;
   logic int_o;
   logic int_oe;
   logic rst_o;
   logic rst_oe;
   logic sqw;
   // open-drain wire levels with pull-ups
   logic int_n;
   logic rst_n;
   assign int_n = int_oe ? int_o : 1'b1;
   assign rst_n = rst_oe ? rst_o : 1'b1;
   modport device (
      input req, wr, addr, wdata, kick,
      output ack, rdata, int_o, int_oe, rst_o, rst_oe, sqw
   );
   modport host (
      output req, wr, addr, wdata, kick,
      input ack, rdata, int_n, rst_n, sqw
   );
endinterface : rtc_link_if

// ### rtl/rtc_host.sv
`timescale 1ns/1ps
module rtc_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   rtc_link_if.host lnk
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_a;
      logic [7:0] w_d;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      rtc_pkg::hstate_t hs;
      logic [4:0] laddr;
      logic [7:0] lwdata;
      logic lwr;
      logic req;
      logic [7:0] last_rd;
      logic kick;
   } host_state_t;

   host_state_t st_ff;
   host_state_t nxt_st;

   always_comb begin
      logic launch;
      logic launch_wr;
      launch = 1'b0;
      launch_wr = 1'b0;
      nxt_st = st_ff;
      nxt_st.req = 1'b0;
      // write channel: address and data taken in either order
      if (awvalid && st_ff.awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_a = awaddr;
      end
      if (wvalid && st_ff.wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_d = wstrb[0] ? wdata[7:0] : st_ff.w_d;
      end
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = rtc_pkg::OKAY;
         case (st_ff.aw_a)
            rtc_pkg::H_ADDR: nxt_st.laddr = st_ff.w_d[4:0];
            rtc_pkg::H_WDATA: begin
               nxt_st.lwdata = st_ff.w_d;
               launch = 1'b1;
               launch_wr = 1'b1;
            end
            rtc_pkg::H_READ: launch = 1'b1;
            rtc_pkg::H_KICK: nxt_st.kick = st_ff.kick ^ st_ff.w_d[0];
            default: nxt_st.bresp = rtc_pkg::SLVERR;
         endcase
      end
      if (st_ff.bvalid && bready) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
      end
      nxt_st.awready = !nxt_st.aw_got && !(awvalid && st_ff.awready);
      nxt_st.wready = !nxt_st.w_got && !(wvalid && st_ff.wready);
      // read channel
      if (arvalid && st_ff.arready) begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = rtc_pkg::OKAY;
         case (araddr)
            rtc_pkg::H_ADDR: nxt_st.rdata = {27'h0000000, st_ff.laddr};
            rtc_pkg::H_WDATA: nxt_st.rdata = {24'h000000, st_ff.lwdata};
            rtc_pkg::H_READ: nxt_st.rdata = 32'h00000000;
            rtc_pkg::H_STAT: begin
               nxt_st.rdata = {23'h000000, st_ff.hs != rtc_pkg::H_IDLE, st_ff.last_rd};
            end
            rtc_pkg::H_KICK: nxt_st.rdata = {31'h00000000, st_ff.kick};
            default: begin
               nxt_st.rdata = 32'h00000000;
               nxt_st.rresp = rtc_pkg::SLVERR;
            end
         endcase
      end
      if (st_ff.rvalid && rready) begin
         nxt_st.rvalid = 1'b0;
         nxt_st.arready = 1'b1;
      end
      // link sequencer; a launch while busy is dropped
      case (st_ff.hs)
         rtc_pkg::H_IDLE: begin
            if (launch) begin
               nxt_st.lwr = launch_wr;
               nxt_st.req = 1'b1;
               nxt_st.hs = rtc_pkg::H_WAIT;
            end
         end
         rtc_pkg::H_WAIT: begin
            if (lnk.ack) begin
               if (!st_ff.lwr) begin
                  nxt_st.last_rd = lnk.rdata;
               end
               nxt_st.hs = rtc_pkg::H_IDLE;
            end
         end
         default: nxt_st.hs = rtc_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.hs <= rtc_pkg::H_IDLE;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign awready = st_ff.awready;
   assign wready = st_ff.wready;
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign arready = st_ff.arready;
   assign rvalid = st_ff.rvalid;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign lnk.req = st_ff.req;
   assign lnk.wr = st_ff.lwr;
   assign lnk.addr = st_ff.laddr;
   assign lnk.wdata = st_ff.lwdata;
   assign lnk.kick = st_ff.kick;
endmodule : rtc_host

// ### bench/rtc_link_assertions.sv
`timescale 1ns/1ps
module rtc_link_assertions #(
   parameter int REC_CYCLES = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req,
   input wire logic wr,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic int_o,
   input wire logic int_oe,
   input wire logic rst_o,
   input wire logic rst_oe,
   input wire logic sqw
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // length of the current reset pulse, compared when it ends
   logic [31:0] run_ff;
   logic [31:0] nxt_run;
   always_comb begin
      nxt_run = rst_oe ? run_ff + 32'h1 : 32'h0;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_ff <= 32'h0;
      end else begin
         run_ff <= nxt_run;
      end
   end
   property p_ack_after_req; req |=> ack; endproperty
   a_ack_after_req: assert property (p_ack_after_req) else $error("no ack after request");
   property p_ack_cause; ack |-> $past(req); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_ack_pulse; ack |=> !ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_req_gap; req |=> !req; endproperty
   a_req_gap: assert property (p_req_gap) else $error("request before ack");
   property p_rdata_hold; !ack |-> $stable(rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved without ack");
   property p_int_od; int_oe |-> !int_o; endproperty
   a_int_od: assert property (p_int_od) else $error("interrupt pin driven high");
   property p_rst_od; rst_oe |-> !rst_o; endproperty
   a_rst_od: assert property (p_rst_od) else $error("reset pin driven high");
   property p_rst_len; $fell(rst_oe) |-> run_ff == REC_CYCLES; endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
   property p_rst_sqw; $rose(rst_oe) |-> !sqw; endproperty
   a_rst_sqw: assert property (p_rst_sqw) else $error("square wave left on");
   property p_sqw_off;
      req && wr && addr == rtc_pkg::A_ALMON && !wdata[rtc_pkg::B_SQUARE_OUTPUT_ENABLE] |-> ##[1:3] !sqw;
   endproperty
   a_sqw_off: assert property (p_sqw_off) else $error("square wave not stopped");
endmodule : rtc_link_assertions

// ### bench/rtc_alarm_watchdog_sqw_test.sv
`timescale 1ns/1ps
module rtc_alarm_watchdog_sqw_test;
   localparam int REC = 20;
   localparam int LIMIT = 100000;
   logic aclk, aresetn, osc_tick, backup;
   logic [7:0] cur_time, awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata, s;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int err_count, n_tests, cyc, n, t;
   rtc_link_if rtc_link_if_inst ();
   rtc_device #(.REC_CYCLES(REC)) rtc_device_inst (.aclk(aclk), .aresetn(aresetn),
      .osc_tick(osc_tick), .backup(backup), .cur_sec(cur_time), .cur_min(cur_time),
      .cur_hour(cur_time), .cur_date(cur_time), .cur_month(cur_time),
      .lnk(rtc_link_if_inst.device));
   rtc_host rtc_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .lnk(rtc_link_if_inst.host));
   rtc_link_assertions #(.REC_CYCLES(REC)) rtc_link_assertions_inst (.aclk(aclk),
      .aresetn(aresetn), .req(rtc_link_if_inst.req), .wr(rtc_link_if_inst.wr),
      .addr(rtc_link_if_inst.addr), .wdata(rtc_link_if_inst.wdata),
      .ack(rtc_link_if_inst.ack), .rdata(rtc_link_if_inst.rdata),
      .int_o(rtc_link_if_inst.int_o), .int_oe(rtc_link_if_inst.int_oe),
      .rst_o(rtc_link_if_inst.rst_o), .rst_oe(rtc_link_if_inst.rst_oe),
      .sqw(rtc_link_if_inst.sqw));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task final_report();
      $display("mismatches %0d, comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   always @(posedge aclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_count++;
         final_report();
      end
   end
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1 && bready));
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1 && rready));
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   // poll busy; the link answers in a cycle, so a few reads suffice
   task link_wait();
      int k;
      k = 0;
      do begin
         axi_rd(rtc_pkg::H_STAT, s);
         k++;
      end while (s[rtc_pkg::H_BUSY] !== 1'b0 && k < 20);
      check(s[rtc_pkg::H_BUSY], 0);
   endtask : link_wait
   task link_wr(input logic [4:0] a, input logic [7:0] d);
      axi_wr(rtc_pkg::H_ADDR, {27'h0, a});
      axi_wr(rtc_pkg::H_WDATA, {24'h0, d});
      link_wait();
   endtask : link_wr
   task link_chk(input logic [4:0] a, input logic [7:0] exp);
      axi_wr(rtc_pkg::H_ADDR, {27'h0, a});
      axi_wr(rtc_pkg::H_READ, 32'h0);
      link_wait();
      check(s[7:0], exp);
   endtask : link_chk
   // pick 1 watches the interrupt wire, 0 the square-wave pin
   task toggles(input bit pick, input int len);
      logic prev, now;
      t = 0;
      @(posedge aclk);
      prev = pick ? rtc_link_if_inst.int_n : rtc_link_if_inst.sqw;
      repeat (len) begin
         @(posedge aclk);
         now = pick ? rtc_link_if_inst.int_n : rtc_link_if_inst.sqw;
         if (now !== prev) t++;
         prev = now;
      end
   endtask : toggles
   task wait_low(input bit pick);
      n = 0;
      while ((pick ? rtc_link_if_inst.int_n : rtc_link_if_inst.rst_n) !== 1'b0 && n < 70000) begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_low
   task t_reset();
      link_chk(rtc_pkg::A_WD, 8'h00);
      link_chk(rtc_pkg::A_ALMON, 8'h00);
      link_chk(rtc_pkg::A_FLAGS, 8'h00);
      link_chk(rtc_pkg::A_SQR, 8'h00);
      link_chk(rtc_pkg::A_CTRL, rtc_pkg::CTRL_RST);
      check(rtc_link_if_inst.int_n, 1);
      check(rtc_link_if_inst.rst_n, 1);
      axi_rd(8'h20, s);
      check(resp, rtc_pkg::SLVERR);
      check(s, 32'h0);
      axi_wr(8'h24, 32'h1);
      check(resp, rtc_pkg::SLVERR);
   endtask : t_reset
   task t_outpin();
      link_wr(rtc_pkg::A_CTRL, 8'h00);
      repeat (3) @(posedge aclk);
      check(rtc_link_if_inst.int_n, 0);
      link_wr(rtc_pkg::A_CTRL, 8'h80);
      repeat (3) @(posedge aclk);
      check(rtc_link_if_inst.int_n, 1);
   endtask : t_outpin
   task t_sqw();
      link_wr(rtc_pkg::A_ALMON, 8'h40);
      for (int c = 0; c < 5; c++) begin
         link_wr(rtc_pkg::A_SQR, 8'(c << 4));
         link_chk(rtc_pkg::A_SQR, 8'(c << 4));
         toggles(1'b0, 64);
         check(t, c == 0 ? 0 : c == 1 ? 64 : 64 >> c);
      end
      link_wr(rtc_pkg::A_ALMON, 8'h00);
      repeat (4) @(posedge aclk);
      toggles(1'b0, 64);
      check({t[7:0], rtc_link_if_inst.sqw}, 9'h0);
   endtask : t_sqw
   task t_wd_irq();
      link_wr(rtc_pkg::A_CTRL, 8'hC0);
      link_wr(rtc_pkg::A_WD, 8'h04);
      toggles(1'b1, 3000);
      check(t, 0);
      axi_wr(rtc_pkg::H_KICK, 32'h1);
      wait_low(1'b1);
      check(n >= 4080 && n <= 4110, 1);
      link_chk(rtc_pkg::A_FLAGS, 8'h80);
      link_chk(rtc_pkg::A_FLAGS, 8'h00);
      check(rtc_link_if_inst.int_n, 0);
      link_wr(rtc_pkg::A_WD, 8'h00);
      repeat (4) @(posedge aclk);
      toggles(1'b1, 256);
      check(t, 4);
      link_wr(rtc_pkg::A_CTRL, 8'h80);
   endtask : t_wd_irq
   task t_wd_rst();
      link_wr(rtc_pkg::A_ALMON, 8'hE0);
      link_wr(rtc_pkg::A_CTRL, 8'hC0);
      link_wr(rtc_pkg::A_WD, 8'h84);
      wait_low(1'b0);
      check(n >= 4060 && n <= 4100, 1);
      n = 0;
      while (rtc_link_if_inst.rst_n === 1'b0 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      check(n, REC);
      link_chk(rtc_pkg::A_WD, 8'h00);
      link_chk(rtc_pkg::A_ALMON, 8'h00);
      link_chk(rtc_pkg::A_CTRL, 8'h80);
      link_chk(rtc_pkg::A_FLAGS, 8'h80);
   endtask : t_wd_rst
   task t_alarm();
      link_wr(rtc_pkg::A_ALDATE, 8'hC0);
      link_wr(rtc_pkg::A_ALHOUR, 8'h80);
      link_wr(rtc_pkg::A_ALMIN, 8'h80);
      link_wr(rtc_pkg::A_ALSEC, 8'h80);
      // leave the pointer off the flags address or the alarm stays silent
      // only one seconds tick fits the run, so it is taken in back-up mode
      backup <= 1'b1;
      link_wr(rtc_pkg::A_ALMON, 8'hA0);
      wait_low(1'b1);
      check(n < 66000, 1);
      repeat (50) @(posedge aclk);
      check(rtc_link_if_inst.int_n, 0);
      link_chk(rtc_pkg::A_FLAGS, 8'h40);
      check(rtc_link_if_inst.int_n, 1);
      link_chk(rtc_pkg::A_FLAGS, 8'h00);
      repeat (500) @(posedge aclk);
      check(rtc_link_if_inst.int_n, 1);
      link_wr(rtc_pkg::A_ALDATE, 8'h00);
      link_wr(rtc_pkg::A_ALHOUR, 8'h00);
      link_wr(rtc_pkg::A_ALMIN, 8'h00);
      link_wr(rtc_pkg::A_ALSEC, 8'h00);
      link_chk(rtc_pkg::A_ALDATE, 8'h00);
   endtask : t_alarm
   initial begin
      err_count = 0;
      n_tests = 0;
      cyc = 0;
      aresetn = 1'b0;
      osc_tick = 1'b1;
      backup = 1'b0;
      cur_time = 8'h01;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_outpin();
      t_sqw();
      t_wd_irq();
      t_wd_rst();
      t_alarm();
      final_report();
   end
endmodule : rtc_alarm_watchdog_sqw_test
